// file: common/fsp_pkg.sv
// Purpose: Shared constants and types for the flash sector protection host controller
// Assumes: 250 MHz system clock, x16 parallel flash bus with 26 word address bits
// Notes:   Register offsets are byte addresses on a 32-bit APB bus

package fsp_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 4000;
  localparam int T_POR_NS      = 35000;  // Power-up wait before first bus cycle
  localparam int T_RST_NS      = 200;    // Reset pin low pulse
  localparam int T_RDY_NS      = 1000;   // Wait after reset pin release
  localparam int T_ACC_NS      = 100;    // Read strobe to data valid
  localparam int T_WRP_NS      = 35;     // Write strobe low width
  localparam int T_REC_NS      = 20;     // Strobes high between cycles
  localparam int POR_CYC = (T_POR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CYC = (T_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RDY_CYC = (T_RDY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRP_CYC = (T_WRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REC_CYC = (T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W   = 16;

  // ==========================================================================
  // Flash address layout (word address)
  // ==========================================================================
  localparam int ADDR_W      = 26;
  localparam int SECT_LSB    = 16;   // Sector field is top bit down to this bit
  localparam int CMD_PAT_MSB = 10;   // Command pattern sits in bits 10..0
  localparam int SECT_W      = ADDR_W - SECT_LSB;
  localparam int DQ_W        = 16;

  // ==========================================================================
  // Flash status words
  // ==========================================================================
  localparam int ECC_CODE_BIT   = 2;   // Single-bit fix in the check code
  localparam int ECC_DATA_BIT   = 1;   // Single-bit fix in the 16 data words
  localparam int ECC_PAGE_WORDS = 16;
  localparam int GUARD_BIT      = 0;   // Guard bit sits in the data LSB
  localparam int LOCK_PERSIST_BIT  = 1;
  localparam int LOCK_PASSWORD_BIT = 2;
  localparam int OTP_BYTES      = 1024;
  localparam int OTP_PART_BYTES = 512;

  // ==========================================================================
  // APB register map
  // ==========================================================================
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  localparam int CTRL_WP_REL   = 0;   // 1 releases the write-protect pin high
  localparam int CTRL_CFG_DONE = 1;   // Persistent guards configured
  localparam int CTRL_RESET    = 0;
  localparam int ST_BUSY     = 0;
  localparam int ST_ERR      = 1;
  localparam int ST_GUARD    = 2;
  localparam int ST_ECC_DATA = 3;
  localparam int ST_ECC_CODE = 4;
  localparam int ST_READY    = 5;

  // ==========================================================================
  // Operations
  // ==========================================================================
  typedef enum logic [2:0] {
    OP_WRITE      = 3'h0,
    OP_READ       = 3'h1,
    OP_GUARD_READ = 3'h2,
    OP_ECC_READ   = 3'h3,
    OP_LOCK_CLEAR = 3'h4,
    OP_LOCK_PROG  = 3'h5,
    OP_HW_RESET   = 3'h6
  } fsp_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq_out;
    logic              dq_oe;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
  } fsp_pins_t;

  localparam fsp_pins_t PINS_IDLE = '{addr: '0, dq_out: '0, dq_oe: 1'b0,
                                      ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};

endpackage

// file: rtl/fsp_bus_cycle.sv
// Purpose: One timed read or write cycle on the asynchronous flash bus
// Assumes: Caller holds request fields stable while o_busy is high
// Notes:   All pins come from flops; data bus is released outside writes

`timescale 1ns/1ps
`default_nettype none

module fsp_bus_cycle
  import fsp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_start,
  input  wire logic              i_write,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DQ_W-1:0]   i_wdata,
  input  wire logic [DQ_W-1:0]   i_dq_in,
  output logic                   o_busy,
  output logic                   o_done,
  output logic [DQ_W-1:0]        o_rdata,
  output fsp_pins_t              o_pins
);

  typedef enum logic [3:0] {
    C_IDLE   = 4'b0001,
    C_SETUP  = 4'b0010,
    C_STROBE = 4'b0100,
    C_REC    = 4'b1000
  } fsp_cyc_t;

  fsp_cyc_t         state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             wr_q;
  fsp_pins_t        pins_d;

  // ==========================================================================
  // Sequencing
  // ==========================================================================
  wire logic cnt_end = (cnt_q == '0);
  wire logic [CNT_W-1:0] strobe_len = wr_q ? CNT_W'(WRP_CYC - 1) : CNT_W'(ACC_CYC - 1);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_end ? cnt_q : cnt_q - CNT_W'(1);
    pins_d  = o_pins;
    case (state_q)
      C_IDLE: begin
        if (i_start) begin
          state_d       = C_SETUP;
          pins_d.addr   = i_addr;
          pins_d.dq_out = i_wdata;
          pins_d.dq_oe  = i_write;
          pins_d.ce_n   = 1'b0;
        end
      end
      C_SETUP: begin
        state_d     = C_STROBE;
        cnt_d       = strobe_len;
        pins_d.we_n = ~wr_q;
        pins_d.oe_n = wr_q;
      end
      C_STROBE: begin
        if (cnt_end) begin
          state_d     = C_REC;
          cnt_d       = CNT_W'(REC_CYC - 1);
          pins_d.we_n = 1'b1;
          pins_d.oe_n = 1'b1;
          pins_d.ce_n = 1'b1;
        end
      end
      C_REC: begin
        if (cnt_end) begin
          state_d      = C_IDLE;
          pins_d.dq_oe = 1'b0;
        end
      end
      default: state_d = C_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= C_IDLE;
      cnt_q   <= '0;
      wr_q    <= 1'b0;
      o_pins  <= PINS_IDLE;
      o_done  <= 1'b0;
      o_rdata <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      o_pins  <= pins_d;
      o_done  <= (state_q == C_REC) && cnt_end;
      if (state_q == C_IDLE && i_start) begin
        wr_q <= i_write;
      end
      if (state_q == C_STROBE && cnt_end && !wr_q) begin
        o_rdata <= i_dq_in;
      end
    end
  end

  assign o_busy = (state_q != C_IDLE);

endmodule

`default_nettype wire

// file: rtl/fsp_host_ctrl.sv
// Purpose: Host-side controller that drives a NOR flash's protection features
// Assumes: Software programs it over APB; flash pins are synchronous to i_clk
// Notes:   Command codes are supplied by software as raw address/data words
//
// Our own choices: register access over APB and the address map.

`timescale 1ns/1ps
`default_nettype none

module fsp_host_ctrl
  import fsp_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC
)(
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            i_vcc_low,
  input  wire logic [DQ_W-1:0] i_dq_in,
  output fsp_pins_t            o_flash,
  output logic                 o_rst_n,
  output logic                 o_wp_n
);

  typedef enum logic [4:0] {
    S_POR   = 5'b00001,
    S_IDLE  = 5'b00010,
    S_CYCLE = 5'b00100,
    S_RST   = 5'b01000,
    S_RDY   = 5'b10000
  } fsp_state_t;

  fsp_state_t       state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0]       ctrl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DQ_W-1:0]  wdata_q;
  logic [DQ_W-1:0]  rdata_q;
  fsp_op_t          op_q;
  logic             err_q, guard_q, ecc_data_q, ecc_code_q;
  logic             start_q;
  logic             cyc_busy, cyc_done;
  logic [DQ_W-1:0]  cyc_rdata;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  wire logic setup    = psel && !penable;
  wire logic acc_wr   = psel && penable && pwrite && pready;
  wire logic hit_ctrl = (paddr == REG_CTRL);
  wire logic hit_addr = (paddr == REG_ADDR);
  wire logic hit_wdat = (paddr == REG_WDATA);
  wire logic hit_cmd  = (paddr == REG_CMD);
  wire logic hit_stat = (paddr == REG_STATUS);
  wire logic hit_rdat = (paddr == REG_RDATA);
  wire logic mapped   = hit_ctrl || hit_addr || hit_wdat || hit_cmd || hit_stat || hit_rdat;
  wire logic idle     = (state_q == S_IDLE);
  wire logic [31:0] status_word = {26'h0, idle, ecc_code_q, ecc_data_q, guard_q, err_q,
                                   !idle};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {30'h0, ctrl_q} :
    hit_addr ? {{(32 - ADDR_W){1'b0}}, addr_q} :
    hit_wdat ? {16'h0, wdata_q} :
    hit_cmd  ? {29'h0, op_q} :
    hit_stat ? status_word :
    hit_rdat ? {16'h0, rdata_q} : 32'h0;

  // ==========================================================================
  // Command launch and checks
  // ==========================================================================
  wire logic    cmd_wr   = acc_wr && hit_cmd;
  wire fsp_op_t cmd_op   = fsp_op_t'(pwdata[2:0]);
  wire logic    op_write = (cmd_op == OP_WRITE) || (cmd_op == OP_LOCK_CLEAR) ||
                           (cmd_op == OP_LOCK_PROG);
  wire logic    op_valid = (pwdata[2:0] <= 3'(OP_HW_RESET));
  // Programming a lock mode bit writes a 0 there; both at once is illegal
  wire logic both_modes = !wdata_q[LOCK_PERSIST_BIT] && !wdata_q[LOCK_PASSWORD_BIT];
  // Lock clear only once guards are configured by software
  wire logic early_lock = (cmd_op == OP_LOCK_CLEAR) && !ctrl_q[CTRL_CFG_DONE];
  wire logic refuse = !op_valid || (op_write && i_vcc_low) ||
                      early_lock || ((cmd_op == OP_LOCK_PROG) && both_modes);
  wire logic launch = cmd_wr && idle && !refuse;
  // Guard reads use offset 0 of the sector; sector field is bits top..16
  wire logic [ADDR_W-1:0] sect_base = {addr_q[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
  wire logic [ADDR_W-1:0] cyc_addr  = (op_q == OP_GUARD_READ) ? sect_base : addr_q;
  wire logic cyc_write = (op_q == OP_WRITE) || (op_q == OP_LOCK_CLEAR) ||
                         (op_q == OP_LOCK_PROG);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  wire logic cnt_end = (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_end ? cnt_q : cnt_q - CNT_W'(1);
    case (state_q)
      S_POR: begin
        if (cnt_end) begin
          state_d = S_IDLE;  // No strobes until power-up has settled
        end
      end
      S_IDLE: begin
        if (launch && cmd_op == OP_HW_RESET) begin
          state_d = S_RST;   // Pin reset recovers from an unknown state
          cnt_d   = CNT_W'(RST_CYC - 1);
        end else if (launch) begin
          state_d = S_CYCLE;
        end
      end
      S_CYCLE: begin
        if (cyc_done) begin
          state_d = S_IDLE;
        end
      end
      S_RST: begin
        if (cnt_end) begin
          state_d = S_RDY;
          cnt_d   = CNT_W'(RDY_CYC - 1);
        end
      end
      S_RDY: begin
        if (cnt_end) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= S_POR;
      cnt_q   <= CNT_W'(POR_CYCLES - 1);
      o_rst_n <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      o_rst_n <= (state_d != S_RST);
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q  <= 2'(CTRL_RESET);
      addr_q  <= '0;
      wdata_q <= '0;
      op_q    <= OP_READ;
      start_q <= 1'b0;
    end else begin
      start_q <= launch && (cmd_op != OP_HW_RESET);
      if (acc_wr && hit_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (acc_wr && hit_addr && idle) begin
        addr_q <= pwdata[ADDR_W-1:0];
      end
      if (acc_wr && hit_wdat && idle) begin
        wdata_q <= pwdata[DQ_W-1:0];
      end
      if (launch) begin
        op_q <= cmd_op;
      end
    end
  end

  // ==========================================================================
  // Results
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      err_q      <= 1'b0;
      guard_q    <= 1'b0;
      ecc_data_q <= 1'b0;
      ecc_code_q <= 1'b0;
      rdata_q    <= '0;
    end else begin
      if (cmd_wr) begin
        err_q <= refuse || !idle;
      end
      if (cyc_done && !cyc_write) begin
        rdata_q <= cyc_rdata;
      end
      if (cyc_done && op_q == OP_GUARD_READ) begin
        guard_q <= cyc_rdata[GUARD_BIT];  // 0 = sector protected
      end
      if (cyc_done && op_q == OP_ECC_READ) begin
        ecc_code_q <= cyc_rdata[ECC_CODE_BIT];  // Reserved bits dropped
        ecc_data_q <= cyc_rdata[ECC_DATA_BIT];
      end
    end
  end

  // ==========================================================================
  // APB answer and pins
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      o_wp_n  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= rd_mux;
        pslverr <= !mapped;
      end
      // Pin held low keeps the boot sector guarded regardless of other bits
      o_wp_n <= ctrl_q[CTRL_WP_REL];
    end
  end

  fsp_bus_cycle u_cycle (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_start  (start_q),
    .i_write  (cyc_write),
    .i_addr   (cyc_addr),
    .i_wdata  (wdata_q),
    .i_dq_in  (i_dq_in),
    .o_busy   (cyc_busy),
    .o_done   (cyc_done),
    .o_rdata  (cyc_rdata),
    .o_pins   (o_flash)
  );

  wire logic unused_ok = cyc_busy;

endmodule

`default_nettype wire

// file: dv/fsp_flash_model.sv
// Purpose: Behavioural flash device seen by the protection host controller
// Assumes: One bus write per command word; command codes are plain defaults
// Notes:   Released data lines show the inverse of the last value read
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter logic [15:0] CMD_GUARD = 16'h00E0,
  parameter logic [15:0] CMD_ECC   = 16'h0075,
  parameter logic [15:0] CMD_EXIT  = 16'h0090,
  parameter logic [15:0] CMD_PROT  = 16'h00A1,
  parameter logic [15:0] CMD_LOCK  = 16'h0070,
  // Lock method is fixed for the life of the part
  parameter logic        PW_MODE   = 1'b0
)(
  input  wire fsp_pins_t   i_pins,
  input  wire logic        i_rst_n,
  output logic [DQ_W-1:0]  o_dq
);
  logic [1023:0]     guard;
  logic [1:0]        mode;
  logic              lock;
  logic [DQ_W-1:0]   last;
  logic [DQ_W-1:0]   rd;
  wire logic [SECT_W-1:0] sa;
  // ==========================================================================
  // Overlays and read data
  // ==========================================================================
  assign sa = i_pins.addr[ADDR_W-1:SECT_LSB];
  always_comb begin
    if (mode == 2'h1) begin
      rd = {15'h7FFF, guard[sa]};
    end else if (mode == 2'h2) begin
      rd = {13'h1FFF, i_pins.addr[4] ^ i_pins.addr[7], i_pins.addr[5], 1'b1};
    end else begin
      rd = i_pins.addr[15:0] ^ 16'hA5A5;
    end
  end
  assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? rd : ~last;
  always @(posedge i_pins.oe_n) last = rd;
  initial begin
    guard = '1;
    mode = 2'h0;
    lock = 1'b1;
    last = 16'h0;
  end
  always @(negedge i_rst_n) begin
    guard = '1;
    mode = 2'h0;
    lock = !PW_MODE;
  end
  // ==========================================================================
  // Command decode, unknown words leave the mode unchanged
  // ==========================================================================
  always @(posedge i_pins.we_n) begin
    if (i_rst_n === 1'b1) begin
      if (i_pins.dq_out == CMD_EXIT) begin
        mode = 2'h0;
      end else if (mode == 2'h2) begin
        mode = 2'h2;
      end else if (i_pins.dq_out == CMD_ECC && mode == 2'h0) begin
        mode = 2'h2;
      end else if (i_pins.dq_out == CMD_GUARD) begin
        mode = 2'h1;
      end else if (mode == 2'h1 && i_pins.dq_out[15:1] == CMD_PROT[15:1]) begin
        guard[sa] = i_pins.dq_out[0];
      end else if (i_pins.dq_out == CMD_LOCK) begin
        lock = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/fsp_host_ctrl_props.sv
// Purpose: Port-level assertions for the protection host controller
// Assumes: Flash commands are issued only while the controller is idle
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module fsp_host_ctrl_props
  import fsp_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        i_vcc_low,
  input  wire fsp_pins_t   o_flash,
  input  wire logic        o_rst_n,
  input  wire logic        o_wp_n
);
  logic [15:0]  por_q;
  wire logic    acc_cmd;
  wire logic    wr_op;
  assign acc_cmd = psel && penable && pwrite && paddr == REG_CMD;
  assign wr_op = pwdata[2:0] == 3'h0 || pwdata[2:0] == 3'h4 || pwdata[2:0] == 3'h5;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      por_q <= 16'h0;
    end else if (por_q != 16'hFFFF) begin
      por_q <= por_q + 16'h1;
    end
  end
  chk_por_quiet: assert property (por_q < POR_CYCLES |-> o_flash.ce_n)
    else $error("strobe during power-up wait");
  chk_vcc_no_write: assert property (acc_cmd && i_vcc_low && wr_op |=> o_flash.we_n[*8])
    else $error("write cycle below lockout");
  chk_guard_offset: assert property (acc_cmd && pwdata[2:0] == 3'h2
    |-> ##[1:4] ($fell(o_flash.ce_n) && o_flash.addr[15:0] == 16'h0))
    else $error("guard read not at sector offset zero");
  chk_we_width: assert property ($fell(o_flash.we_n)
    |-> (!o_flash.we_n)[*8] ##1 !o_flash.we_n ##[1:3] o_flash.we_n)
    else $error("write strobe width wrong");
  chk_we_drive: assert property (!o_flash.we_n |-> o_flash.dq_oe && !o_flash.ce_n)
    else $error("write strobe without data drive");
  chk_read_release: assert property (!o_flash.oe_n |-> !o_flash.dq_oe && o_flash.we_n)
    else $error("data driven during read strobe");
  chk_rst_pulse: assert property ($fell(o_rst_n) |-> ##[40:60] $rose(o_rst_n))
    else $error("reset pulse length wrong");
  chk_rst_quiet: assert property (!o_rst_n |-> o_flash.ce_n && o_flash.we_n)
    else $error("strobe during reset pulse");
  chk_wp_follow: assert property (psel && penable && pwrite && paddr == REG_CTRL
    |=> ##1 o_wp_n == $past(pwdata[CTRL_WP_REL], 2))
    else $error("write-protect pin not updated");
endmodule
bind fsp_host_ctrl fsp_host_ctrl_props #(.POR_CYCLES(POR_CYCLES)) i_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .i_vcc_low(i_vcc_low), .o_flash(o_flash),
  .o_rst_n(o_rst_n), .o_wp_n(o_wp_n));
`default_nettype wire

// file: dv/fsp_host_ctrl_test.sv
// Purpose: Self-checking bench for the protection host controller
// Assumes: Short power-up wait parameter; flash model answers at once
// Notes:   Random sectors and pages come from a bench shift register
`timescale 1ns/1ps
`default_nettype none
module fsp_host_ctrl_test
  import fsp_pkg::*;
;
  localparam int POR_SIM = 20;
  logic              i_clk;
  logic              i_resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              i_vcc_low;
  logic [DQ_W-1:0]   i_dq_in;
  fsp_pins_t         o_flash;
  logic              o_rst_n;
  logic              o_wp_n;
  logic [31:0]       rd;
  logic [31:0]       st;
  logic              er;
  logic [15:0]       lf;
  logic [25:0]       a;
  logic [25:0]       s0;
  logic              g[1024];
  int                fails;
  int                checks;
  fsp_host_ctrl #(.POR_CYCLES(POR_SIM)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_vcc_low(i_vcc_low), .i_dq_in(i_dq_in), .o_flash(o_flash), .o_rst_n(o_rst_n),
    .o_wp_n(o_wp_n));
  fsp_flash_model i_flash (.i_pins(o_flash), .i_rst_n(o_rst_n), .o_dq(i_dq_in));
  // ==========================================================================
  // Clock, helpers and bus tasks
  // ==========================================================================
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input string n, input logic s, input logic x);
    checks++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s expected %b seen %b", n, x, s);
    end
  endtask
  task report_and_stop;
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task op(input logic [2:0] c, input logic [25:0] ad, input logic [15:0] d);
    int n;
    apb(1'b1, REG_ADDR, 32'(ad));
    apb(1'b1, REG_WDATA, 32'(d));
    apb(1'b1, REG_CMD, 32'(c));
    for (n = 0; n < 200; n++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    chk("op_done", rd[ST_BUSY], 1'b0);
    st = rd;
  endtask
  initial begin
    repeat (50000) @(posedge i_clk);
    fails++;
    report_and_stop;
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    {i_resetn, psel, penable, pwrite, i_vcc_low} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lf = 16'hC293;
    foreach (g[i]) g[i] = 1'b1;
    repeat (8) @(posedge i_clk);
    chk("pready_rst", pready, 1'b0);
    chk("wp_rst", o_wp_n, 1'b0);
    i_resetn <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    chk("ready_early", rd[ST_READY], 1'b0);
    apb(1'b1, REG_CMD, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("err_early", rd[ST_ERR], 1'b1);
    repeat (POR_SIM + 4) @(posedge i_clk);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmap_err", er, 1'b1);
    chk("unmap_data", rd === 32'h0, 1'b1);
    chk("wp_release", o_wp_n, 1'b1);
    op(3'h0, 26'h0, i_flash.CMD_GUARD);
    repeat (4) begin
      lf = nx(lf);
      a[25:16] = lf[9:0];
      lf = nx(lf);
      a[15:0] = lf | 16'h1;
      op(3'h2, a, 16'h0);
      chk("guard_fresh", st[ST_GUARD], g[a[25:16]]);
      op(3'h0, a, i_flash.CMD_PROT & 16'hFFFE);
      g[a[25:16]] = 1'b0;
      op(3'h2, a, 16'h0);
      chk("guard_set", st[ST_GUARD], g[a[25:16]]);
      apb(1'b0, REG_RDATA, 32'h0);
      chk("guard_lsb", rd[0], g[a[25:16]]);
    end
    s0 = a;
    op(3'h0, 26'h0, i_flash.CMD_EXIT);
    op(3'h0, 26'h0, i_flash.CMD_ECC);
    repeat (6) begin
      lf = nx(lf);
      a = 26'(lf);
      op(3'h3, a, 16'h0);
      chk("ecc_data", st[ST_ECC_DATA], a[5]);
      chk("ecc_code", st[ST_ECC_CODE], a[4] ^ a[7]);
    end
    op(3'h0, 26'h0, i_flash.CMD_EXIT);
    i_vcc_low <= 1'b1;
    op(3'h0, 26'h0, i_flash.CMD_LOCK);
    chk("vcc_write", st[ST_ERR], 1'b1);
    op(3'h1, 26'h0, 16'h0);
    chk("vcc_read", st[ST_ERR], 1'b0);
    i_vcc_low <= 1'b0;
    op(3'h4, 26'h0, i_flash.CMD_LOCK);
    chk("lock_early", st[ST_ERR], 1'b1);
    apb(1'b1, REG_CTRL, 32'h3);
    op(3'h4, 26'h0, i_flash.CMD_LOCK);
    chk("lock_clear", st[ST_ERR], 1'b0);
    op(3'h5, 26'h0, 16'hFFF9);
    chk("mode_both", st[ST_ERR], 1'b1);
    op(3'h5, 26'h0, 16'hFFFD);
    chk("mode_one", st[ST_ERR], 1'b0);
    op(3'h6, 26'h0, 16'h0);
    foreach (g[i]) g[i] = 1'b1;
    op(3'h0, 26'h0, i_flash.CMD_GUARD);
    op(3'h2, s0, 16'h0);
    chk("guard_after_rst", st[ST_GUARD], g[s0[25:16]]);
    report_and_stop;
  end
endmodule
`default_nettype wire
